/* File: include/pwr_seq_pkg.sv */
// Shared constants and types for the power sequencer and its host end
// Functional notes
// - Unsequenced resources stay off until sequence ends
// - Programmed delay between successive resource actions
// - Sequence is an ordered list of writes
// - Release reset after sequence and stable clock
// - Gating override releases reset without clocks
// - Hold mode: start on request, reset high
// - Hold mode: shut down 8 s without hold
// - Host drives hold pin high and keeps it
// - Hold pin falling low means OFF request
// - Auto mode sets keep-alive bit, stays active
// - Non-self-set bit uses hold-mode timeout behaviour
// - Host writes keep-alive bit and keeps it
// - First boot pin selects configuration set
// - Both boot pins choose sequence selector
// - Normal and forced voltage share one value
// - Sequence may branch on boot pin levels
// - Static settings may be overwritten later
// - User writes override sequence after completion
// - Host pulses sleep pin twice after restart
// - Host may toggle sleep polarity low-high-low
// - OFF honoured only without another ON condition
package pwr_seq_pkg;
  localparam int CLK_MHZ = 250;
  localparam int TIMEOUT_S = 8;
  localparam int SLOW_HZ = 32768;
  localparam int SLOW_DIV = CLK_MHZ * 1000000 / SLOW_HZ;
  localparam int TIMEOUT_TICKS = TIMEOUT_S * SLOW_HZ;
  localparam int N_RES = 8;
  localparam int ADDR_W = 3;
  localparam int VOLTAGE_SELECT_FIELD_W = 7;
  localparam int PROG_DEPTH = 16;
  localparam int PC_W = 4;
  localparam int DLY_W = 8;
  // Power-down list base and length of the host restart kick
  localparam logic [PC_W-1:0] DOWN_BASE = 4'hC;
  localparam logic [2:0] KICK_START = 3'h4;
  // Instruction opcodes and resource modes
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_BRANCH = 2'h1;
  localparam logic [1:0] OP_END = 2'h2;
  localparam logic [1:0] RES_OFF = 2'h0;
  localparam logic [1:0] RES_ON = 2'h1;
  localparam logic [1:0] RES_SLEEP = 2'h2;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_UP = 3'b001,
    ST_WAIT_CLK = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_DOWN = 3'b100
  } seq_state_t;
  typedef struct packed {
    logic [1:0] op;
    logic [ADDR_W-1:0] res;
    logic [1:0] mode;
    logic [DLY_W-1:0] delay;
    logic [PC_W-1:0] target;
  } instr_t;
endpackage

/* File: include/pwr_ack_if.sv */
// Interface joining the sequencer and the host acknowledge logic
`timescale 1ns/1ps
interface pwr_ack_if;
  logic power_on_button_pin;
  logic power_keep_pin;
  logic reset_out;
  logic keep_alive_wr;
  logic keep_alive_wdata;
  logic keep_alive_bit;
  logic sleep_request_pin;
  logic sleep_pin_polarity_bit;
  modport device (input power_on_button_pin, input power_keep_pin, input keep_alive_wr,
    input keep_alive_wdata, output reset_out, output keep_alive_bit);
  modport host (output power_on_button_pin, output power_keep_pin, output keep_alive_wr,
    output keep_alive_wdata, output sleep_request_pin, output sleep_pin_polarity_bit,
    input reset_out, input keep_alive_bit);
endinterface

/* File: logic/pwr_sequencer.sv */
// Power sequencer with reset release and power-on acknowledge
`timescale 1ns/1ps
module pwr_sequencer
  import pwr_seq_pkg::*;
#(
  parameter int TIMEOUT_TICKS_P = TIMEOUT_TICKS,
  parameter int SLOW_DIV_P = SLOW_DIV
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  pwr_ack_if.device link,
  input wire logic i_config_set_pin,
  input wire logic i_sequence_select_pin,
  input wire logic i_auto_keep_alive_mode,
  input wire logic i_hold_pin_mode,
  input wire logic i_oscillator_enable_config,
  input wire logic i_xtal_stable,
  input wire logic i_ext_slow_stable,
  input wire logic i_gate_override,
  input wire logic [VOLTAGE_SELECT_FIELD_W-1:0] i_voltage_select_field_set0,
  input wire logic [VOLTAGE_SELECT_FIELD_W-1:0] i_voltage_select_field_set1,
  input wire logic i_user_wr,
  input wire logic [ADDR_W-1:0] i_user_res,
  input wire logic [1:0] i_user_mode,
  input wire logic i_user_voltage_select_field_wr,
  input wire logic [VOLTAGE_SELECT_FIELD_W-1:0] i_user_voltage_select_field,
  input wire logic i_prog_wr,
  input wire logic [PC_W-1:0] i_prog_addr,
  input wire logic [$bits(instr_t)-1:0] i_prog_data,
  output logic [2*N_RES-1:0] o_res_mode,
  output logic [VOLTAGE_SELECT_FIELD_W-1:0] o_switcher_voltage_reg,
  output logic [VOLTAGE_SELECT_FIELD_W-1:0] o_switcher_forced_voltage_reg,
  output logic o_config_set,
  output logic [1:0] o_seq_select,
  output logic o_seq_done,
  output logic [2:0] o_state
);
  localparam int TCNT_W = $clog2(TIMEOUT_TICKS_P + 1);
  localparam int DIV_W = $clog2(SLOW_DIV_P + 1);

  seq_state_t state, next_state;
  instr_t prog [PROG_DEPTH];
  logic [PC_W-1:0] pc;
  logic [DLY_W-1:0] dly;
  logic [TCNT_W-1:0] tcnt;
  logic [DIV_W-1:0] div;
  logic held;
  logic keep_bit;
  logic reset_out_q;
  logic strap_taken;

  // config set from first boot pin
  wire logic cfg_set = i_config_set_pin;
  // sequence selector from both boot pins
  wire logic [1:0] seq_sel = i_config_set_pin ? 2'h2 : {1'b0, i_sequence_select_pin};
  wire instr_t cur = prog[pc];
  // Slow tick stands in for the slow clock domain: one clock, enable pulse only
  wire logic slow_tick = (div == DIV_W'(SLOW_DIV_P - 1));
  wire logic clk_ok = i_gate_override ||
    (i_oscillator_enable_config ? i_xtal_stable : i_ext_slow_stable);
  // register bit replaces pin when not in hold-pin mode
  wire logic ack = i_hold_pin_mode ? link.power_keep_pin : keep_bit;
  // OFF only if no other ON condition holds
  wire logic other_on = i_hold_pin_mode ? keep_bit : link.power_keep_pin;
  // fall of acknowledge after it was seen
  wire logic off_req = held && !ack && !other_on;
  wire logic timeout = !held && !i_auto_keep_alive_mode && tcnt == TCNT_W'(TIMEOUT_TICKS_P);
  wire logic auto_off = i_auto_keep_alive_mode && !keep_bit && !link.power_keep_pin;
  wire logic step = (dly == '0);
  // branch taken on boot pin levels
  wire logic br_take = cur.mode == {i_config_set_pin, i_sequence_select_pin};

  always_comb begin
    next_state = state;
    case (state)
      ST_OFF: if (link.power_on_button_pin) next_state = ST_UP;
      ST_UP: if (step && cur.op == OP_END) next_state = ST_WAIT_CLK;
      ST_WAIT_CLK: if (clk_ok) next_state = ST_ACTIVE;
      ST_ACTIVE: if (off_req || timeout || auto_off) next_state = ST_DOWN;
      ST_DOWN: if (step && cur.op == OP_END) next_state = ST_OFF;
      default: next_state = ST_OFF;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) state <= ST_OFF;
    else state <= next_state;
  end

  // Program store has no reset; it must be loaded before the first power-on request
  always_ff @(posedge i_clock) begin
    if (i_prog_wr) prog[i_prog_addr] <= instr_t'(i_prog_data);
  end

  // Sequence program: entries from selector*4 up; power-down from its own base
  wire logic [PC_W-1:0] up_base = {seq_sel, 2'b00};
  wire logic [PC_W-1:0] down_base = DOWN_BASE;
  wire logic running = (state == ST_UP) || (state == ST_DOWN);
  // Start address reloads on every pass through OFF, so a new selector takes effect
  wire logic seq_load = (state == ST_OFF) || (state == ST_ACTIVE && next_state == ST_DOWN);
  wire logic [PC_W-1:0] load_pc = (state == ST_OFF) ? up_base : down_base;
  wire logic [PC_W-1:0] step_pc = (cur.op == OP_BRANCH && br_take) ? cur.target : pc + PC_W'(1);

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc <= '0;
      dly <= '0;
    end else if (seq_load) begin
      pc <= load_pc;
      dly <= '0;
    end else if (running && !step) begin
      dly <= dly - DLY_W'(1);
    end else if (running && cur.op != OP_END) begin
      pc <= step_pc;
      dly <= cur.delay;
    end
  end

  // A sequence write wins over a user write; user writes are refused outside ACTIVE
  wire logic seq_res_wr = running && step && cur.op == OP_WRITE;
  wire logic usr_res_wr = (state == ST_ACTIVE) && i_user_wr;
  // One shared strap value feeds both voltage registers; it is sampled once after reset
  wire logic [VOLTAGE_SELECT_FIELD_W-1:0] strap_voltage_select_field = cfg_set ? i_voltage_select_field_set1 : i_voltage_select_field_set0;
  wire logic usr_voltage_select_field_wr = (state == ST_ACTIVE) && i_user_voltage_select_field_wr;

  // resources reset to off, only sequence writes before done
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) o_res_mode <= '0;
    else if (seq_res_wr) o_res_mode[2*cur.res +: 2] <= cur.mode;
    else if (usr_res_wr) o_res_mode[2*i_user_res +: 2] <= i_user_mode;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_taken <= 1'b0;
      o_switcher_voltage_reg <= '0;
      o_switcher_forced_voltage_reg <= '0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      // both loaded from one shared value
      o_switcher_voltage_reg <= strap_voltage_select_field;
      o_switcher_forced_voltage_reg <= strap_voltage_select_field;
    end else if (usr_voltage_select_field_wr) begin
      o_switcher_voltage_reg <= i_user_voltage_select_field;
      o_switcher_forced_voltage_reg <= i_user_voltage_select_field;
    end
  end

  // Divider free-runs, so the timeout may fire up to one slow period early
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) div <= '0;
    else div <= slow_tick ? '0 : div + DIV_W'(1);
  end

  // Saturates at the limit so a long wait cannot wrap back under it
  // timeout counted on slow tick from ACTIVE entry
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) tcnt <= '0;
    else if (state != ST_ACTIVE || held) tcnt <= '0;
    else if (slow_tick && tcnt != TCNT_W'(TIMEOUT_TICKS_P)) tcnt <= tcnt + TCNT_W'(1);
  end

  // Acknowledge is latched so that only a later drop counts as an OFF request
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) held <= 1'b0;
    else if (state != ST_ACTIVE) held <= 1'b0;
    else if (ack) held <= 1'b1;
  end

  // Self-set wins over a host write that lands on the same edge
  wire logic keep_self_set = (state == ST_WAIT_CLK) && (next_state == ST_ACTIVE) && i_auto_keep_alive_mode;

  // keep-alive bit self-set at end of power-up
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) keep_bit <= 1'b0;
    else if (keep_self_set) keep_bit <= 1'b1;
    else if (link.keep_alive_wr) keep_bit <= link.keep_alive_wdata;
    else if (state == ST_OFF) keep_bit <= 1'b0;
  end

  // Taken from next_state so the release lines up with the ACTIVE state output
  // reset released once ACTIVE
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) reset_out_q <= 1'b0;
    else reset_out_q <= (next_state == ST_ACTIVE);
  end

  // Done and state copies are registered from next_state, in step with the reset output; strap copies from the pins
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_config_set <= 1'b0;
      o_seq_select <= '0;
      o_seq_done <= 1'b0;
      o_state <= '0;
    end else begin
      o_config_set <= cfg_set;
      o_seq_select <= seq_sel;
      o_seq_done <= (next_state == ST_ACTIVE);
      o_state <= next_state;
    end
  end

  assign link.reset_out = reset_out_q;
  assign link.keep_alive_bit = keep_bit;
endmodule

/* File: logic/pwr_host_ack.sv */
// Host end: drives ON request, hold pin, keep-alive writes and sleep kicks
`timescale 1ns/1ps
module pwr_host_ack
  import pwr_seq_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  pwr_ack_if.host link,
  input wire logic i_power_on,
  input wire logic i_stay_on,
  input wire logic i_hold_pin_mode,
  input wire logic i_restart_kick,
  input wire logic i_kick_by_polarity,
  output logic o_cpu_running
);
  logic on_q, keep_q, kwr_q, kdat_q, slp_q, pol_q, rst_seen;
  logic [2:0] kick;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      on_q <= 1'b0;
      keep_q <= 1'b0;
      kwr_q <= 1'b0;
      kdat_q <= 1'b0;
      rst_seen <= 1'b0;
      o_cpu_running <= 1'b0;
    end else begin
      on_q <= i_power_on;
      rst_seen <= link.reset_out;
      o_cpu_running <= link.reset_out;
      // hold pin high while staying on
      keep_q <= i_hold_pin_mode && link.reset_out && i_stay_on;
      // keep-alive written and kept equal to stay-on
      kwr_q <= !i_hold_pin_mode && link.reset_out && (link.keep_alive_bit != i_stay_on) && !kwr_q;
      kdat_q <= i_stay_on;
    end
  end

  // pulse sleep pin twice; polarity 0-1-0
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      kick <= '0;
      slp_q <= 1'b1;
      pol_q <= 1'b0;
    end else begin
      if (i_restart_kick && link.reset_out && !rst_seen) kick <= KICK_START;
      else if (kick != '0) kick <= kick - 3'h1;
      slp_q <= !(kick[0] && !i_kick_by_polarity);
      pol_q <= kick[1] && i_kick_by_polarity;
    end
  end

  assign link.power_on_button_pin = on_q;
  assign link.power_keep_pin = keep_q;
  assign link.keep_alive_wr = kwr_q;
  assign link.keep_alive_wdata = kdat_q;
  assign link.sleep_request_pin = slp_q;
  assign link.sleep_pin_polarity_bit = pol_q;
endmodule

/* File: verification/pwr_seq_assertions.sv */
// Assertions on the acknowledge link and sequencer status outputs
`timescale 1ns/1ps
module pwr_seq_assertions
  import pwr_seq_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic reset_out,
  input wire logic power_keep_pin,
  input wire logic keep_alive_bit,
  input wire logic [2:0] o_state,
  input wire logic o_config_set,
  input wire logic [1:0] o_seq_select,
  input wire logic [VOLTAGE_SELECT_FIELD_W-1:0] o_switcher_voltage_reg,
  input wire logic [VOLTAGE_SELECT_FIELD_W-1:0] o_switcher_forced_voltage_reg,
  input wire logic i_config_set_pin,
  input wire logic i_sequence_select_pin,
  input wire logic i_hold_pin_mode,
  input wire logic i_auto_keep_alive_mode,
  input wire logic i_oscillator_enable_config,
  input wire logic i_xtal_stable,
  input wire logic i_ext_slow_stable,
  input wire logic i_gate_override
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  wire clk_ok = i_gate_override | (i_oscillator_enable_config ? i_xtal_stable : i_ext_slow_stable);
  // Pin drops while the keep bit is not holding the device up
  sequence s_keep_dropped;
    i_hold_pin_mode && power_keep_pin && !keep_alive_bit && o_state == ST_ACTIVE ##1 !power_keep_pin;
  endsequence
  sequence s_left_active;
    ##[0:3] o_state != ST_ACTIVE;
  endsequence
  a_release_in_active: assert property ($rose(reset_out) |-> o_state == ST_ACTIVE)
    else $error("release outside active");
  a_release_clock_ok: assert property ($rose(reset_out) |-> $past(clk_ok))
    else $error("release without clock");
  a_held_before_active: assert property (o_state inside {ST_OFF, ST_UP, ST_WAIT_CLK} |-> !reset_out)
    else $error("reset high too early");
  a_volt_regs_match: assert property (o_switcher_voltage_reg == o_switcher_forced_voltage_reg)
    else $error("voltage regs differ");
  a_config_set_pin: assert property ($past(i_rst_n) |-> o_config_set == i_config_set_pin)
    else $error("config set wrong");
  a_seq_select_pins: assert property ($past(i_rst_n) |->
    o_seq_select == {i_config_set_pin, !i_config_set_pin && i_sequence_select_pin})
    else $error("sequence select wrong");
  a_auto_sets_bit: assert property ($rose(reset_out) && i_auto_keep_alive_mode && !i_hold_pin_mode
    |-> keep_alive_bit)
    else $error("keep bit not set");
  a_pin_drop_off: assert property (s_keep_dropped |-> s_left_active)
    else $error("pin drop not honoured");
endmodule

/* File: verification/power_sequence_and_on_acknowledge_tb_top.sv */
// Bench joining the sequencer and host ends over the acknowledge link
`timescale 1ns/1ps
module power_sequence_and_on_acknowledge_tb_top
  import pwr_seq_pkg::*;
;
  logic i_clock = 0, i_rst_n = 0, i_config_set_pin = 0, i_sequence_select_pin = 0, i_power_on = 0;
  logic i_auto_keep_alive_mode = 0, i_hold_pin_mode = 0, i_oscillator_enable_config = 1, i_xtal_stable = 1;
  logic i_ext_slow_stable = 1, i_gate_override = 0, i_user_wr = 0, i_user_voltage_select_field_wr = 0, i_prog_wr = 0;
  logic i_stay_on = 0, i_restart_kick = 0, i_kick_by_polarity = 0, o_config_set, o_seq_done, o_cpu_running;
  logic [1:0] i_user_mode = '0, o_seq_select;
  logic [2:0] i_user_res = '0, o_state;
  logic [3:0] i_prog_addr = '0;
  logic [6:0] i_user_voltage_select_field = '0, i_voltage_select_field_set0 = 7'h15, i_voltage_select_field_set1 = 7'h2a;
  logic [6:0] o_switcher_voltage_reg, o_switcher_forced_voltage_reg;
  logic [$bits(instr_t)-1:0] i_prog_data = '0;
  logic [15:0] o_res_mode;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int slp_falls = 0;
  int pol_rises = 0;
  logic slp_prev = 1'b1;
  logic pol_prev = 1'b0;
  pwr_ack_if link();
  pwr_sequencer #(.TIMEOUT_TICKS_P(4), .SLOW_DIV_P(4)) u_pwr_sequencer (.i_clock, .i_rst_n, .link,
    .i_config_set_pin, .i_sequence_select_pin, .i_auto_keep_alive_mode, .i_hold_pin_mode,
    .i_oscillator_enable_config, .i_xtal_stable, .i_ext_slow_stable, .i_gate_override, .i_voltage_select_field_set0,
    .i_voltage_select_field_set1, .i_user_wr, .i_user_res, .i_user_mode, .i_user_voltage_select_field_wr, .i_user_voltage_select_field, .i_prog_wr,
    .i_prog_addr, .i_prog_data, .o_res_mode, .o_switcher_voltage_reg, .o_switcher_forced_voltage_reg,
    .o_config_set, .o_seq_select, .o_seq_done, .o_state);
  pwr_host_ack u_pwr_host_ack (.i_clock, .i_rst_n, .link, .i_power_on, .i_stay_on, .i_hold_pin_mode,
    .i_restart_kick, .i_kick_by_polarity, .o_cpu_running);
  pwr_seq_assertions u_pwr_seq_assertions (.i_clock, .i_rst_n, .reset_out(link.reset_out),
    .power_keep_pin(link.power_keep_pin), .keep_alive_bit(link.keep_alive_bit), .o_state,
    .o_config_set, .o_seq_select, .o_switcher_voltage_reg, .o_switcher_forced_voltage_reg,
    .i_config_set_pin, .i_sequence_select_pin, .i_hold_pin_mode, .i_auto_keep_alive_mode,
    .i_oscillator_enable_config, .i_xtal_stable, .i_ext_slow_stable, .i_gate_override);
  always #2 i_clock = ~i_clock;
  // Counts the kicks the host end gives the sleep pin and the polarity bit
  always @(posedge i_clock) begin
    slp_prev <= link.sleep_request_pin;
    pol_prev <= link.sleep_pin_polarity_bit;
    if (slp_prev && !link.sleep_request_pin) slp_falls++;
    if (!pol_prev && link.sleep_pin_polarity_bit) pol_rises++;
  end
  // Five runs need well under a tenth of this
  always @(posedge i_clock) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      summarize();
    end
  end
  task automatic tick(int k = 1);
    repeat (k) @(posedge i_clock);
    #1;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_for(logic [2:0] s, output int n);
    n = 0;
    while (o_state !== s && n < 300) begin
      tick();
      n++;
    end
  endtask
  // Selector s starts at 4*s; entry 0 skips resource 7 when both pins are low,
  // entry 8 skips resource 3 when both pins are high
  function automatic logic [18:0] prog(logic [3:0] a);
    case (a)
      4'h0: return {OP_BRANCH, 3'h0, 2'h0, 8'h03, 4'h2};
      4'h1: return {OP_WRITE, 3'h7, RES_ON, 8'h03, 4'h0};
      4'h2: return {OP_WRITE, 3'h0, RES_ON, 8'h03, 4'h0};
      4'h4: return {OP_WRITE, 3'h1, RES_ON, 8'h03, 4'h0};
      4'h8: return {OP_BRANCH, 3'h0, 2'h3, 8'h03, 4'ha};
      4'h9: return {OP_WRITE, 3'h3, RES_ON, 8'h03, 4'h0};
      4'ha: return {OP_WRITE, 3'h2, RES_ON, 8'h03, 4'h0};
      4'hc, 4'hd, 4'he: return {OP_WRITE, a[2:0] - 3'h4, RES_OFF, 8'h03, 4'h0};
      default: return {OP_END, 17'h0};
    endcase
  endfunction
  task automatic boot(logic [1:0] p);
    i_rst_n = 0;
    {i_config_set_pin, i_sequence_select_pin} = p;
    tick(20);
    i_rst_n = 1;
    tick(2);
    chk("config set", 16'(p[1]), 16'(o_config_set));
    chk("seq select", 16'({p[1], !p[1] & p[0]}), 16'(o_seq_select));
    chk("voltage", p[1] ? 16'h002a : 16'h0015, 16'(o_switcher_voltage_reg));
    for (int i = 0; i < 16; i++) begin
      i_prog_wr = 1;
      i_prog_addr = 4'(i);
      i_prog_data = prog(4'(i));
      tick();
    end
    i_prog_wr = 0;
  endtask
  task automatic run(logic [1:0] p, logic h, logic a, logic s, logic [3:0] c, logic [15:0] e);
    int n;
    boot(p);
    {i_oscillator_enable_config, i_xtal_stable, i_ext_slow_stable, i_gate_override} = c;
    i_hold_pin_mode = h;
    i_auto_keep_alive_mode = a;
    i_stay_on = s;
    i_restart_kick = s;
    i_kick_by_polarity = p[1];
    slp_falls = 0;
    pol_rises = 0;
    i_power_on = 1;
    wait_for(ST_ACTIVE, n);
    chk("step delay", 16'h0001, 16'(n > 3));
    if (c == 4'h8) begin
      chk("clock gate", 16'(ST_WAIT_CLK), 16'(o_state));
      i_gate_override = 1;
      wait_for(ST_ACTIVE, n);
    end
    chk("released", 16'h0001, 16'(link.reset_out));
    chk("seq done", 16'h0001, 16'(o_seq_done));
    chk("resources", e, o_res_mode);
    if (a && !h) chk("keep bit", 16'h0001, 16'(link.keep_alive_bit));
    i_power_on = 0;
    tick(8);
    chk("early", 16'h0001, 16'(link.reset_out));
    chk("cpu running", 16'h0001, 16'(o_cpu_running));
    chk("sleep pulses", 16'((s && !p[1]) ? 2 : 0), 16'(slp_falls));
    chk("polarity pulses", 16'(s && p[1]), 16'(pol_rises));
    tick(40);
    chk("alive", 16'(s), 16'(link.reset_out));
    if (s) begin
      i_user_wr = 1;
      i_user_res = 3'h6;
      i_user_mode = RES_ON;
      i_user_voltage_select_field_wr = 1;
      i_user_voltage_select_field = 7'h33;
      tick();
      i_user_wr = 0;
      i_user_voltage_select_field_wr = 0;
      i_stay_on = 0;
      tick();
      chk("user res", e | 16'h1000, o_res_mode);
      chk("user volt", 16'h0033, 16'(o_switcher_forced_voltage_reg));
    end
    wait_for(ST_OFF, n);
    chk("off res", 16'h0000, o_res_mode & 16'h003f);
    chk("off reset", 16'h0000, 16'(link.reset_out));
    chk("off done", 16'h0000, 16'(o_seq_done));
    chk("cpu stopped", 16'h0000, 16'(o_cpu_running));
  endtask
  initial begin
    run(2'h0, 0, 1, 1, 4'hc, 16'h0001);
    run(2'h1, 1, 0, 0, 4'h2, 16'h0004);
    run(2'h2, 1, 0, 1, 4'h8, 16'h0050);
    run(2'h3, 0, 0, 0, 4'hc, 16'h0010);
    run(2'h0, 0, 0, 1, 4'h2, 16'h0001);
    summarize();
  end
endmodule
